// file: sim/qai_adc_model.sv
// converter model answering each start with one code after a random delay
`timescale 1ns/1ps
module qai_adc_model
  import qai_pkg::*;
(
  input  wire logic                         clock_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         start_in,
  input  wire logic [1:0]                   chan_in,
  input  wire logic [3:0][QAI_CODE_W-1:0]   codes_in,
  input  wire logic                         step_en_in,
  output logic                              valid_out,
  output logic [QAI_CODE_W-1:0]             code_out
);
  int              wait_q;
  logic [1:0]      chan_q;
  logic [3:0][2:0] step_q;

  // step adds 0..7 per sample so eight samples of a channel average to code + 3
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_q    <= 0;
      chan_q    <= 2'h0;
      step_q    <= '0;
      valid_out <= 1'b0;
      code_out  <= 12'h000;
    end else begin
      valid_out <= 1'b0;
      // released code lines show garbage, not the last result
      if (valid_out) begin
        code_out <= ~code_out;
      end
      if (start_in) begin
        wait_q <= 1 + ($urandom % 6);
        chan_q <= chan_in;
      end else if (wait_q == 1) begin
        valid_out         <= 1'b1;
        code_out          <= codes_in[chan_q] + (step_en_in ? 12'(step_q[chan_q]) : 12'h000);
        step_q[chan_q]    <= step_q[chan_q] + 3'h1;
        wait_q            <= 0;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule : qai_adc_model

// file: sim/test_qai_top.sv
// self-checking bench of the quad analog input block
`timescale 1ns/1ps
module test_qai_top;
  import qai_pkg::*;
  localparam int SLOT = 8;
  logic                   clock_in, arst_n_in, word_sw, avg_sw, host_power, step_en;
  logic [7:0]             range_sw, wr_data, rd_data, d;
  logic                   adc_valid, adc_start, wr, rd, irq;
  logic [1:0]             adc_chan, next_chan;
  logic [11:0]            adc_code;
  logic [3:0]             addr;
  logic [15:0]            w0, w1, w2, w3;
  logic [2:0]             words_used;
  logic                   ready, bad, open_lamp, cnt_lamp;
  logic [3:0][11:0]       codes, c;
  logic [3:0][15:0]       words;
  int                     errors, checks_done;
  assign words = {w3, w2, w1, w0};

  qai_top #(.SLOT_CYCLES(SLOT)) uut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .range_sw_in(range_sw), .word_sw_in(word_sw), .avg_sw_in(avg_sw),
    .host_power_in(host_power), .adc_valid_in(adc_valid), .adc_code_in(adc_code),
    .addr_in(addr), .wr_data_in(wr_data), .wr_in(wr), .rd_in(rd),
    .adc_start_out(adc_start), .adc_chan_out(adc_chan), .in_word0_out(w0),
    .in_word1_out(w1), .in_word2_out(w2), .in_word3_out(w3), .words_used_out(words_used),
    .ready_lamp_out(ready), .bad_setting_lamp_out(bad), .open_wire_lamp_out(open_lamp),
    .word_count_lamp_out(cnt_lamp), .rd_data_out(rd_data), .irq_out(irq));

  qai_adc_model adc (.clock_in(clock_in), .arst_n_in(arst_n_in), .start_in(adc_start),
    .chan_in(adc_chan), .codes_in(codes), .step_en_in(step_en), .valid_out(adc_valid),
    .code_out(adc_code));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr    <= a;
    wr_data <= v;
    wr      <= 1'b1;
    @(posedge clock_in);
    wr      <= 1'b0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_in);
    rd   <= 1'b0;
    #1;
    v = rd_data;
  endtask : bus_rd

  function automatic logic [15:0] exp_word(input logic [7:0] sw, input logic four, input int ch,
                                           input logic [11:0] k);
    logic [11:0] s;
    s = k ^ 12'h800;
    if (!four && ch > 1) return 16'h0000;
    case ({sw[2*ch], sw[2*ch+1]})
      2'h3: return {{4{s[11]}}, s};
      2'h1: return {4'h0, k};
      2'h2: return {(k <= QAI_OPEN_CODE), 3'h0, k};
      default: return 16'h0000;
    endcase
  endfunction : exp_word

  // earlier conversions may still carry old settings, so n must cover two refreshes
  task automatic run_trial(input logic [7:0] sw, input logic four, input logic pw,
                           input logic [3:0][11:0] k, input int n, input logic [11:0] off);
    int         seen;
    logic [3:0] flags;
    logic [11:0] e;
    seen = 0;
    flags = 4'h0;
    @(posedge clock_in);
    range_sw   <= sw;
    word_sw    <= four;
    host_power <= pw;
    codes      <= k;
    for (int i = 0; i < 40 * n && seen < n; i++) begin
      @(posedge clock_in);
      if (adc_valid) seen++;
    end
    check_val(16'(seen), 16'(n), "conversions finished");
    repeat (4) @(posedge clock_in);
    #1;
    for (int ch = 0; ch < 4; ch++) begin
      e = k[ch] + off;
      flags[ch] = ({sw[2*ch], sw[2*ch+1]} == 2'h2) && (four || ch < 2) && (e <= QAI_OPEN_CODE);
      check_val(words[ch], exp_word(sw, four, ch, e), "input word");
    end
    check_val(16'(words_used), four ? 16'h0004 : 16'h0002, "words used");
    check_val(16'(cnt_lamp), 16'(four), "word count lamp");
    check_val(16'(bad), 16'(sw == 8'h00), "bad setting lamp");
    check_val(16'(ready), 16'(pw && sw != 8'h00), "ready lamp");
    check_val(16'(open_lamp), 16'(|flags), "open wire lamp");
    bus_rd(QAI_REG_STATE, d);
    check_val(16'(d), {8'h00, flags, four, |flags, sw == 8'h00, pw && sw != 8'h00},
              "state register");
  endtask : run_trial

  // conversions must visit channels 1, 2, 3, 4 and wrap
  always @(posedge clock_in) begin
    if (arst_n_in && adc_start) begin
      check_val(16'(adc_chan), 16'(next_chan), "channel order");
      next_chan <= adc_chan + 2'h1;
    end
  end

  initial begin
    #(30000 * 100);
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    arst_n_in = 1'b0;
    range_sw = 8'hFF;
    word_sw = 1'b1;
    avg_sw = 1'b0;
    host_power = 1'b1;
    step_en = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    codes = '0;
    next_chan = 2'h0;
    errors = 0;
    checks_done = 0;
    void'($urandom(32'hc323));
    repeat (4) @(posedge clock_in);
    arst_n_in <= 1'b1;
    bus_rd(QAI_REG_MASK, d);
    check_val(16'(d), 16'(QAI_MASK_RST), "mask reset");
    bus_wr(4'hC, 8'hFF);
    bus_rd(4'hC, d);
    check_val(16'(d), 16'h0000, "unmapped read");
    run_trial(8'hFF, 1'b1, 1'b1, {12'h7FF, 12'h800, 12'hFFF, 12'h000}, 8, 12'h000);
    run_trial(8'hAA, 1'b1, 1'b1, {12'hFD0, 12'h030, 12'hFFF, 12'h000}, 8, 12'h000);
    run_trial(8'h0F, 1'b0, 1'b1, {12'h9AB, 12'h456, 12'h123, 12'hC00}, 8, 12'h000);
    run_trial(8'h00, 1'b1, 1'b1, {12'h111, 12'h222, 12'h333, 12'h444}, 8, 12'h000);
    run_trial(8'hFF, 1'b1, 1'b0, {12'h111, 12'h222, 12'h333, 12'h444}, 8, 12'h000);
    run_trial(8'h55, 1'b1, 1'b1, {12'hFFF, 12'h000, 12'h021, 12'h020}, 8, 12'h000);
    check_val({15'h0000, irq}, 16'h0000, "masked interrupt");
    bus_wr(QAI_REG_MASK, 8'h02);
    repeat (2) @(posedge clock_in);
    #1;
    check_val({15'h0000, irq}, 16'h0001, "open wire interrupt");
    run_trial(8'h55, 1'b1, 1'b1, {12'hFFF, 12'h400, 12'h021, 12'h800}, 8, 12'h000);
    bus_wr(QAI_REG_STATUS, 8'h02);
    repeat (2) @(posedge clock_in);
    #1;
    check_val({15'h0000, irq}, 16'h0000, "cleared interrupt");
    bus_rd(QAI_REG_STATUS, d);
    check_val(16'(d[QAI_ST_OPEN]), 16'h0000, "open status cleared");
    for (int t = 0; t < 4; t++) begin
      d = 8'($urandom);
      if (t[0]) d[7:4] = 4'h0;
      for (int ch = 0; ch < 4; ch++) c[ch] = 12'($urandom);
      run_trial(d, ~t[0], 1'b1, c, 8, 12'h000);
    end
    // eight samples of code + 0..7 average to code + 3, kept clear of overflow
    @(posedge clock_in);
    step_en <= 1'b1;
    avg_sw  <= 1'b1;
    for (int ch = 0; ch < 4; ch++) c[ch] = 12'($urandom) & 12'hFF0;
    run_trial(8'hAA, 1'b1, 1'b1, c, 72, 12'h003);
    finish_test();
  end
endmodule : test_qai_top

// file: verilog/qai_mean.sv
// eight-sample mean per channel, or straight pass of each conversion
`timescale 1ns/1ps
module qai_mean
  import qai_pkg::*;
#(
  parameter int CODE_W = QAI_CODE_W,
  parameter int AVG_N  = QAI_AVG_N
) (
  input  wire logic              clock_in,
  input  wire logic              arst_n_in,
  input  wire logic              avg_en_in,
  input  wire logic              smp_valid_in,
  input  wire logic [1:0]        smp_chan_in,
  input  wire logic [CODE_W-1:0] smp_code_in,
  output logic                   res_valid_out,
  output logic [1:0]             res_chan_out,
  output logic [CODE_W-1:0]      res_code_out
);
  localparam int SH_W  = $clog2(AVG_N);
  localparam int SUM_W = CODE_W + SH_W;
  localparam logic [SH_W-1:0] LAST_ROUND = SH_W'(AVG_N - 1);

  logic [SUM_W-1:0]  acc_ff [QAI_CHANS];
  logic [SH_W-1:0]   round_ff;
  logic              res_valid_ff;
  logic [1:0]        res_chan_ff;
  logic [CODE_W-1:0] res_code_ff;
  wire  [SUM_W-1:0]  nxt_acc  = acc_ff[smp_chan_in] + SUM_W'(smp_code_in);
  wire               last     = avg_en_in && (round_ff == LAST_ROUND);
  wire               emit     = smp_valid_in && (!avg_en_in || last);
  wire               chan_end = smp_chan_in == 2'h3;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < QAI_CHANS; i++) begin
        acc_ff[i] <= '0;
      end
      round_ff <= '0;
    end else if (smp_valid_in) begin
      acc_ff[smp_chan_in] <= (last || !avg_en_in) ? '0 : nxt_acc;
      round_ff <= !avg_en_in ? '0 : (chan_end ? round_ff + 1'b1 : round_ff);
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_valid_ff <= 1'b0;
      res_chan_ff  <= 2'h0;
      res_code_ff  <= '0;
    end else begin
      res_valid_ff <= emit;
      if (emit) begin
        res_chan_ff <= smp_chan_in;
        // the mean drops the fraction; a shift keeps the divider out
        res_code_ff <= avg_en_in ? nxt_acc[SUM_W-1:SH_W] : smp_code_in;
      end
    end
  end

  assign res_valid_out = res_valid_ff;
  assign res_chan_out  = res_chan_ff;
  assign res_code_out  = res_code_ff;
endmodule : qai_mean

// file: verilog/qai_pkg.sv
// constants and types of the quad analog input configuration block
package qai_pkg;
  localparam int          QAI_CHANS     = 4;
  localparam int          QAI_CODE_W    = 12;
  localparam int          QAI_WORD_W    = 16;
  localparam int          QAI_DATA_W    = 8;
  localparam int          QAI_ADDR_W    = 4;
  localparam int          QAI_AVG_N     = 8;
  localparam int          QAI_OPEN_BIT  = 15;
  // clock and conversion slot: 32 conversions per averaged refresh of 72 ms
  localparam int          QAI_CLK_NS    = 100;
  localparam int          QAI_REFRESH_MS = 72;
  localparam int          QAI_SLOT_CYC  = (QAI_REFRESH_MS * 1000000 / QAI_CLK_NS)
                                          / (QAI_CHANS * QAI_AVG_N);
  // codes at or below this read as a broken live-zero input (about 0.95 V)
  localparam logic [11:0] QAI_OPEN_CODE = 12'h020;
  localparam logic [15:0] QAI_WORD_RST  = 16'h0000;
  // register byte addresses
  localparam logic [3:0]  QAI_REG_STATUS = 4'h0;
  localparam logic [3:0]  QAI_REG_MASK   = 4'h4;
  localparam logic [3:0]  QAI_REG_STATE  = 4'h8;
  localparam logic [7:0]  QAI_MASK_RST   = 8'h00;
  // status bit positions
  localparam int          QAI_ST_REFRESH = 0;
  localparam int          QAI_ST_OPEN    = 1;
  localparam int          QAI_ST_BAD     = 2;
  localparam int          QAI_ST_W       = 3;
  // range codes as {even pin, odd pin}
  typedef enum logic [1:0] {
    qai_rng_off  = 2'h0,
    qai_rng_uni  = 2'h1,
    qai_rng_live = 2'h2,
    qai_rng_bip  = 2'h3
  } qai_range_t;
  typedef enum logic [2:0] {
    qai_wait_s  = 3'b001,
    qai_start_s = 3'b010,
    qai_busy_s  = 3'b100
  } qai_state_t;
endpackage : qai_pkg

// file: verilog/qai_top.sv
// quad analog input: switch decode, conversion sequencing, words, lamps, registers
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module qai_top
  import qai_pkg::*;
#(
  parameter int SLOT_CYCLES = QAI_SLOT_CYC
) (
  input  wire logic                  clock_in,
  input  wire logic                  arst_n_in,
  input  wire logic [7:0]            range_sw_in,
  input  wire logic                  word_sw_in,
  input  wire logic                  avg_sw_in,
  input  wire logic                  host_power_in,
  input  wire logic                  adc_valid_in,
  input  wire logic [QAI_CODE_W-1:0] adc_code_in,
  input  wire logic [QAI_ADDR_W-1:0] addr_in,
  input  wire logic [QAI_DATA_W-1:0] wr_data_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic                       adc_start_out,
  output logic [1:0]                 adc_chan_out,
  output logic [QAI_WORD_W-1:0]      in_word0_out,
  output logic [QAI_WORD_W-1:0]      in_word1_out,
  output logic [QAI_WORD_W-1:0]      in_word2_out,
  output logic [QAI_WORD_W-1:0]      in_word3_out,
  output logic [2:0]                 words_used_out,
  output logic                       ready_lamp_out,
  output logic                       bad_setting_lamp_out,
  output logic                       open_wire_lamp_out,
  output logic                       word_count_lamp_out,
  output logic [QAI_DATA_W-1:0]      rd_data_out,
  output logic                       irq_out
);
  localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);
  localparam logic [SLOT_W-1:0] SLOT_END = SLOT_W'(SLOT_CYCLES - 1);

  function automatic qai_range_t chan_range(input logic [7:0] sw, input logic [1:0] ch);
    chan_range = qai_range_t'({sw[{ch, 1'b0}], sw[{ch, 1'b1}]});
  endfunction : chan_range

  function automatic logic [QAI_WORD_W-1:0] fmt_word(input qai_range_t rng,
                                                    input logic [QAI_CODE_W-1:0] code,
                                                    input logic open);
    logic s;
    s = ~code[QAI_CODE_W-1];
    case (rng)
      qai_rng_bip:  fmt_word = {{4{s}}, s, code[QAI_CODE_W-2:0]};
      qai_rng_uni:  fmt_word = {4'h0, code};
      qai_rng_live: fmt_word = {open, 3'h0, code};
      default:      fmt_word = QAI_WORD_RST;
    endcase
  endfunction : fmt_word

  function automatic logic served(input logic [1:0] ch, input logic four);
    served = four || !ch[1];
  endfunction : served

  qai_state_t                  state_ff;
  qai_state_t                  nxt_state;
  logic [SLOT_W-1:0]           slot_ff;
  logic [1:0]                  chan_ff;
  logic                        start_ff;
  logic [QAI_WORD_W-1:0]       word_ff [QAI_CHANS];
  logic [QAI_CHANS-1:0]        open_ff;
  logic                        ready_ff;
  logic                        bad_ff;
  logic                        open_lamp_ff;
  logic                        cnt_lamp_ff;
  logic [2:0]                  used_ff;
  logic [QAI_ST_W-1:0]         status_ff;
  logic [QAI_ST_W-1:0]         mask_ff;
  logic [QAI_DATA_W-1:0]       rd_data_ff;
  logic                        irq_ff;

  logic                        res_valid;
  logic [1:0]                  res_chan;
  logic [QAI_CODE_W-1:0]       res_code;
  wire                         smp_valid = adc_valid_in && (state_ff == qai_busy_s);

  // switch decode
  wire             all_off    = range_sw_in == 8'h00;
  wire             fault      = all_off;
  qai_range_t      res_rng;
  assign res_rng = chan_range(range_sw_in, res_chan);
  wire             res_served = served(res_chan, word_sw_in);
  wire             res_open   = (res_rng == qai_rng_live) && (res_code <= QAI_OPEN_CODE);
  wire [QAI_WORD_W-1:0] res_word = fmt_word(res_rng, res_code, res_open);

  // sequencer: every channel gets its slot, disabled or not, so timing never shrinks
  wire slot_done = slot_ff == SLOT_END;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      qai_wait_s:  nxt_state = slot_done ? qai_start_s : qai_wait_s;
      qai_start_s: nxt_state = qai_busy_s;
      qai_busy_s:  nxt_state = adc_valid_in ? qai_wait_s : qai_busy_s;
      default:     nxt_state = qai_wait_s;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= qai_wait_s;
      slot_ff  <= '0;
      chan_ff  <= 2'h3;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      slot_ff  <= (state_ff != qai_wait_s || slot_done) ? '0 : slot_ff + 1'b1;
      start_ff <= (state_ff == qai_wait_s) && slot_done;
      if ((state_ff == qai_wait_s) && slot_done) begin
        chan_ff <= chan_ff + 2'h1;
      end
    end
  end

  qai_mean #(
    .CODE_W (QAI_CODE_W),
    .AVG_N  (QAI_AVG_N)
  ) u_mean (
    .clock_in      (clock_in),
    .arst_n_in     (arst_n_in),
    .avg_en_in     (avg_sw_in),
    .smp_valid_in  (smp_valid),
    .smp_chan_in   (chan_ff),
    .smp_code_in   (adc_code_in),
    .res_valid_out (res_valid),
    .res_chan_out  (res_chan),
    .res_code_out  (res_code)
  );

  // input words; channels outside the word span read as zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < QAI_CHANS; i++) begin
        word_ff[i] <= QAI_WORD_RST;
      end
      open_ff <= '0;
    end else begin
      for (int i = 0; i < QAI_CHANS; i++) begin
        if (!served(2'(i), word_sw_in)) begin
          word_ff[i] <= QAI_WORD_RST;
          open_ff[i] <= 1'b0;
        end else if (res_valid && res_chan == 2'(i)) begin
          word_ff[i] <= res_word;
          open_ff[i] <= res_open;
        end
      end
    end
  end

  // lamps
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_ff     <= 1'b0;
      bad_ff       <= 1'b0;
      open_lamp_ff <= 1'b0;
      cnt_lamp_ff  <= 1'b0;
      used_ff      <= 3'h0;
    end else begin
      ready_ff     <= host_power_in && !fault;
      bad_ff       <= all_off;
      open_lamp_ff <= |open_ff;
      cnt_lamp_ff  <= word_sw_in;
      used_ff      <= word_sw_in ? 3'h4 : 3'h2;
    end
  end

  // registers: status is write-one-to-clear, a new event beats the clear
  wire                  wr_status = wr_in && addr_in == QAI_REG_STATUS;
  wire                  wr_mask   = wr_in && addr_in == QAI_REG_MASK;
  wire [QAI_ST_W-1:0]   st_set;
  assign st_set[QAI_ST_REFRESH] = res_valid && res_chan == 2'h3;
  assign st_set[QAI_ST_OPEN]    = res_valid && res_served && res_open && !open_ff[res_chan];
  assign st_set[QAI_ST_BAD]     = all_off;
  wire [QAI_ST_W-1:0]   st_clr    = wr_status ? wr_data_in[QAI_ST_W-1:0] : '0;
  wire [QAI_ST_W-1:0]   nxt_status = (status_ff & ~st_clr) | st_set;
  wire [QAI_DATA_W-1:0] state_word = {open_ff, cnt_lamp_ff, open_lamp_ff, bad_ff, ready_ff};
  wire [QAI_DATA_W-1:0] nxt_rd_data =
    !rd_in                      ? '0 :
    addr_in == QAI_REG_STATUS   ? QAI_DATA_W'(status_ff) :
    addr_in == QAI_REG_MASK     ? QAI_DATA_W'(mask_ff) :
    addr_in == QAI_REG_STATE    ? state_word : '0;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_ff  <= '0;
      mask_ff    <= QAI_MASK_RST[QAI_ST_W-1:0];
      rd_data_ff <= '0;
      irq_ff     <= 1'b0;
    end else begin
      status_ff  <= nxt_status;
      mask_ff    <= wr_mask ? wr_data_in[QAI_ST_W-1:0] : mask_ff;
      rd_data_ff <= nxt_rd_data;
      irq_ff     <= |(nxt_status & (wr_mask ? wr_data_in[QAI_ST_W-1:0] : mask_ff));
    end
  end

  assign adc_start_out        = start_ff;
  assign adc_chan_out         = chan_ff;
  assign in_word0_out         = word_ff[0];
  assign in_word1_out         = word_ff[1];
  assign in_word2_out         = word_ff[2];
  assign in_word3_out         = word_ff[3];
  assign words_used_out       = used_ff;
  assign ready_lamp_out       = ready_ff;
  assign bad_setting_lamp_out = bad_ff;
  assign open_wire_lamp_out   = open_lamp_ff;
  assign word_count_lamp_out  = cnt_lamp_ff;
  assign rd_data_out          = rd_data_ff;
  assign irq_out              = irq_ff;

  // checks
  logic [1:0] prev_chan_ff;
  logic       seen_ff;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_chan_ff <= 2'h0;
      seen_ff      <= 1'b0;
    end else if (start_ff) begin
      prev_chan_ff <= chan_ff;
      seen_ff      <= 1'b1;
    end
  end

  sequence bip_zero_s;
    res_valid && res_chan == 2'h0 && res_code == 12'h000 &&
      chan_range(range_sw_in, 2'h0) == qai_rng_bip;
  endsequence

  bad_lamp_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    all_off |=> bad_setting_lamp_out && !ready_lamp_out)
    else $error("bad-setting lamp not lit with all range switches off");

  word_count_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    word_sw_in |=> word_count_lamp_out && words_used_out == 3'h4)
    else $error("four-word mode not shown");

  two_word_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !word_sw_in |=> in_word2_out == 16'h0000 && in_word3_out == 16'h0000 &&
      words_used_out == 3'h2 && !word_count_lamp_out)
    else $error("channels three and four served in two-word mode");

  ready_lamp_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (!host_power_in || fault) |=> !ready_lamp_out)
    else $error("ready lamp lit without power or with a fault");

  chan_order_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    adc_start_out && seen_ff |-> adc_chan_out == prev_chan_ff + 2'h1)
    else $error("channel order broken");

  start_gap_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    adc_start_out |=> !adc_start_out ##1 !adc_start_out)
    else $error("conversion started twice in a row");

  open_only_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    res_valid && res_rng != qai_rng_live |=> !open_ff[$past(res_chan)])
    else $error("open-wire flag on a channel that is not live zero");

  open_clear_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    res_valid && res_served && res_rng == qai_rng_live && !res_open
      |=> !open_ff[$past(res_chan)] ##1 (!open_wire_lamp_out || |open_ff))
    else $error("open-wire flag not cleared on recovery");

  bip_code_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    bip_zero_s |=> in_word0_out == 16'hF800)
    else $error("bipolar low end not two's complement");

  irq_mask_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    |(status_ff & mask_ff) |-> irq_out)
    else $error("unmasked event gave no interrupt");

  rd_mask_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    rd_in && addr_in == QAI_REG_MASK |=> rd_data_out == QAI_DATA_W'($past(mask_ff)))
    else $error("mask read back wrong");

  sequence bip_top_s;
    res_valid && res_chan == 2'h1 && res_code == 12'hFFF && res_rng == qai_rng_bip;
  endsequence

  sequence live_store_s;
    res_valid && res_served && res_rng == qai_rng_live;
  endsequence

  irq_quiet_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (status_ff & mask_ff) == '0 |-> !irq_out)
    else $error("interrupt with no unmasked status bit");

  bad_status_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    all_off |=> status_ff[QAI_ST_BAD])
    else $error("bad-setting status not set");

  open_w1c_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    wr_status && wr_data_in[QAI_ST_OPEN] && !st_set[QAI_ST_OPEN] |=> !status_ff[QAI_ST_OPEN])
    else $error("open-wire status not cleared by write of one");

  refresh_flag_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    res_valid && res_chan == 2'h3 |=> status_ff[QAI_ST_REFRESH])
    else $error("refresh status not set after channel four");

  rd_idle_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !rd_in |=> rd_data_out == '0)
    else $error("read data not zero outside a read");

  rd_status_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    rd_in && addr_in == QAI_REG_STATUS |=> rd_data_out == QAI_DATA_W'($past(status_ff)))
    else $error("status read back wrong");

  rd_state_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    rd_in && addr_in == QAI_REG_STATE |=> rd_data_out == $past(state_word))
    else $error("state read back wrong");

  open_set_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    res_valid && res_served && res_open |=> open_ff[$past(res_chan)])
    else $error("open-wire flag not set");

  open_lamp_on_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    |open_ff |=> open_wire_lamp_out)
    else $error("open-wire lamp dark with a flag set");

  open_lamp_off_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    open_ff == '0 |=> !open_wire_lamp_out)
    else $error("open-wire lamp lit with no flag set");

  unserved_open_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !word_sw_in |=> open_ff[3:2] == 2'h0)
    else $error("open-wire flag on an unserved channel");

  bip_high_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    bip_top_s |=> in_word1_out == 16'h07FF)
    else $error("bipolar high end not two's complement");

  off_word_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    res_valid && res_rng == qai_rng_off |=> word_ff[$past(res_chan)] == QAI_WORD_RST)
    else $error("disabled channel word not zero");

  uni_word_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    res_valid && res_served && res_rng == qai_rng_uni
      |=> word_ff[$past(res_chan)] == {4'h0, $past(res_code)})
    else $error("unipolar word wrong");

  live_word_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    live_store_s |=> word_ff[$past(res_chan)][QAI_OPEN_BIT] == $past(res_open))
    else $error("open-wire bit of the word wrong");

  mean_pass_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    smp_valid && !avg_sw_in |=> res_valid && res_code == $past(adc_code_in))
    else $error("conversion not passed on with averaging off");

  ready_on_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    host_power_in && !fault |=> ready_lamp_out)
    else $error("ready lamp dark with power and no fault");
endmodule : qai_top
